// >>> rtl/rsc_pkg.sv
// Package with opcodes, register map and shared types of the return-stack control block.
package rsc_pkg;

   // ---------------------------------------------------------------
   // Instruction encodings
   // ---------------------------------------------------------------
   localparam logic [15:0] OP_STACK_DISCARD = 16'h0006;
   localparam logic [15:0] OP_STACK_SAVE    = 16'h0005;
   localparam logic [15:0] OP_SOFT_RESET    = 16'h00ff;
   localparam logic [14:0] OP_IRQ_RETURN    = 15'h0008;
   localparam logic [7:0]  OP_LIT_RETURN    = 8'h0c;
   localparam logic [4:0]  OP_REL_SUBCALL   = 5'h1b;
   localparam int          OFFSET_BITS      = 11;
   localparam int          PC_STEP          = 2;

   // ---------------------------------------------------------------
   // Register map, byte addresses of 32-bit words
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_STACK_TOP  = 8'h00;
   localparam logic [7:0] ADDR_ACCUM      = 8'h04;
   localparam logic [7:0] ADDR_FLAGS      = 8'h08;
   localparam logic [7:0] ADDR_BANK       = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
   localparam logic [7:0] ADDR_PC         = 8'h14;
   localparam logic [7:0] ADDR_DEPTH      = 8'h18;
   localparam int         IRQ_EN_HIGH_BIT = 0;
   localparam int         IRQ_EN_LOW_BIT  = 1;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] ACCUM_RESET = 8'h00;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] BANK_RESET  = 8'h00;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_EXEC  = 2'h0,
      ST_FLUSH = 2'h1
   } rsc_state_e_t;

   typedef struct packed {
      logic [7:0] accum;
      logic [7:0] flags;
      logic [7:0] bank;
   } rsc_work_t;

   localparam rsc_work_t WORK_RESET = '{accum: ACCUM_RESET, flags: FLAGS_RESET,
                                        bank: BANK_RESET};

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } rsc_bus_t;

endpackage

// >>> rtl/rsc_core.sv
// Decode and execution of the return-stack and control-flow instructions.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Opcode 0x0006 drops the stack top, no flag change, one cycle.
// - After a drop, the entry below becomes the new stack top.
// - Opcode 0x0005 pushes program counter plus two, one cycle, no flags.
// - A push moves the old stack top one level deeper.
// - Relative call is prefix 11011 with an 11-bit signed word offset.
// - Relative call pushes pc plus two, then jumps by twice the offset.
// - Relative call takes two cycles, target written in the first.
// - Software reset restores every register and flag to its reset value, but raises soft_reset for one cycle.
// - Interrupt return pops the stack into the program counter.
// - Interrupt return sets the high or low global enable, by level exited.
// - With the fast bit set, shadows reload accumulator, flags and bank.
// - Interrupt return leaves the upper and high pc latches alone.
// - Interrupt return changes only the enable of the level exited unless restoring shadows.
// - Opcode 0x0ckk loads the 8-bit literal into the accumulator.
// - Literal return pops the stack into pc, high latch untouched.
module rsc_core #(
   parameter int PCW   = 21,
   parameter int DEPTH = 31
) (
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire rsc_pkg::rsc_bus_t  bus,
   output logic [31:0]             bus_rdata,
   input  wire logic               instr_valid,
   input  wire logic [15:0]        instr,
   output logic                    instr_ready,
   input  wire rsc_pkg::rsc_work_t shadow,
   input  wire logic               irq_exit_high,
   output logic [PCW-1:0]          pc,
   output logic [PCW-1:0]          stack_top,
   output rsc_pkg::rsc_work_t      work,
   output logic                    high_prio_global_irq_enable,
   output logic                    low_prio_global_irq_enable,
   output logic                    soft_reset
);

   localparam int DW = $clog2(DEPTH + 1);
   localparam logic [PCW-1:0] STEP = PCW'(rsc_pkg::PC_STEP);
   localparam logic [DW-1:0]  FULL = DW'(DEPTH);
   localparam logic [DW-1:0]  ONE  = DW'(1);

   typedef struct packed {
      rsc_pkg::rsc_state_e_t     st;
      logic [PCW-1:0]            pc;
      logic [DEPTH-1:0][PCW-1:0] stk;
      logic [DW-1:0]             depth;
      rsc_pkg::rsc_work_t        work;
      logic                      hp_irq_en;
      logic                      lp_irq_en;
      logic                      soft_rst;
      logic [31:0]               rdata;
   } rsc_core_state_t;

   localparam rsc_core_state_t STATE_RESET = '{
      st: rsc_pkg::ST_EXEC, pc: '0, stk: '0, depth: '0,
      work: rsc_pkg::WORK_RESET, hp_irq_en: 1'b0, lp_irq_en: 1'b0,
      soft_rst: 1'b0, rdata: '0};

   rsc_core_state_t state_reg;
   rsc_core_state_t state_next;
   logic [PCW-1:0]  pc_plus2;
   logic [PCW-1:0]  rel_offset;
   logic            take;

   assign take       = instr_valid && (state_reg.st == rsc_pkg::ST_EXEC);
   assign pc_plus2   = state_reg.pc + STEP;
   assign rel_offset = {{(PCW - rsc_pkg::OFFSET_BITS - 1){instr[10]}},
                        instr[rsc_pkg::OFFSET_BITS-1:0], 1'b0};

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      state_next          = state_reg;
      state_next.soft_rst = 1'b0;
      state_next.rdata    = '0;

      // Register port. Instruction effects below override these writes.
      if (bus.rd) begin
         case (bus.addr)
            rsc_pkg::ADDR_STACK_TOP:  state_next.rdata = 32'(state_reg.stk[0]);
            rsc_pkg::ADDR_ACCUM:      state_next.rdata = 32'(state_reg.work.accum);
            rsc_pkg::ADDR_FLAGS:      state_next.rdata = 32'(state_reg.work.flags);
            rsc_pkg::ADDR_BANK:       state_next.rdata = 32'(state_reg.work.bank);
            rsc_pkg::ADDR_IRQ_ENABLE: state_next.rdata = 32'({state_reg.lp_irq_en,
                                                              state_reg.hp_irq_en});
            rsc_pkg::ADDR_PC:         state_next.rdata = 32'(state_reg.pc);
            rsc_pkg::ADDR_DEPTH:      state_next.rdata = 32'(state_reg.depth);
            default:                  state_next.rdata = '0;
         endcase
      end
      if (bus.wr) begin
         case (bus.addr)
            rsc_pkg::ADDR_STACK_TOP:  state_next.stk[0] = bus.wdata[PCW-1:0];
            rsc_pkg::ADDR_ACCUM:      state_next.work.accum = bus.wdata[7:0];
            rsc_pkg::ADDR_FLAGS:      state_next.work.flags = bus.wdata[7:0];
            rsc_pkg::ADDR_BANK:       state_next.work.bank = bus.wdata[7:0];
            rsc_pkg::ADDR_IRQ_ENABLE: begin
               state_next.hp_irq_en = bus.wdata[rsc_pkg::IRQ_EN_HIGH_BIT];
               state_next.lp_irq_en = bus.wdata[rsc_pkg::IRQ_EN_LOW_BIT];
            end
            default: ;
         endcase
      end

      case (state_reg.st)
         rsc_pkg::ST_EXEC: begin
            if (take) begin
               state_next.pc = pc_plus2;
               if (instr == rsc_pkg::OP_STACK_DISCARD) begin
                  // Pop: the entry below moves up, nothing reads the old top.
                  for (int i = 0; i < DEPTH - 1; i++) begin
                     state_next.stk[i] = state_reg.stk[i+1];
                  end
                  state_next.stk[DEPTH-1] = '0;
                  if (state_reg.depth != '0) state_next.depth = state_reg.depth - ONE;
               end else if (instr == rsc_pkg::OP_STACK_SAVE ||
                            instr[15:11] == rsc_pkg::OP_REL_SUBCALL) begin
                  // The pushed top is the value software may just have rewritten.
                  // Walk from the bottom up so each level takes the old value above it.
                  for (int i = DEPTH - 1; i > 0; i--) begin
                     state_next.stk[i] = state_next.stk[i-1];
                  end
                  state_next.stk[0] = pc_plus2;
                  if (state_reg.depth != FULL) state_next.depth = state_reg.depth + ONE;
                  if (instr[15:11] == rsc_pkg::OP_REL_SUBCALL) begin
                     state_next.pc = pc_plus2 + rel_offset;
                     state_next.st = rsc_pkg::ST_FLUSH;
                  end
               end else if (instr == rsc_pkg::OP_SOFT_RESET) begin
                  // Full overwrite: same values as the asynchronous reset, except soft_rst, which is set high.
                  state_next          = STATE_RESET;
                  state_next.soft_rst = 1'b1;
               end else if (instr[15:1] == rsc_pkg::OP_IRQ_RETURN ||
                            instr[15:8] == rsc_pkg::OP_LIT_RETURN) begin
                  // Pop into pc; the pc latches live outside and stay untouched.
                  state_next.pc = state_reg.stk[0];
                  for (int i = 0; i < DEPTH - 1; i++) begin
                     state_next.stk[i] = state_reg.stk[i+1];
                  end
                  state_next.stk[DEPTH-1] = '0;
                  if (state_reg.depth != '0) state_next.depth = state_reg.depth - ONE;
                  state_next.st = rsc_pkg::ST_FLUSH;
                  if (instr[15:8] == rsc_pkg::OP_LIT_RETURN) begin
                     state_next.work.accum = instr[7:0];
                  end else begin
                     if (irq_exit_high) state_next.hp_irq_en = 1'b1;
                     else state_next.lp_irq_en = 1'b1;
                     if (instr[0]) state_next.work = shadow;
                  end
               end
            end
         end
         rsc_pkg::ST_FLUSH: begin
            // Dead cycle after a pc change; only the register port may act.
            state_next.st = rsc_pkg::ST_EXEC;
         end
         default: state_next.st = rsc_pkg::ST_EXEC;
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= STATE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign instr_ready                 = (state_reg.st == rsc_pkg::ST_EXEC);
   assign bus_rdata                   = state_reg.rdata;
   assign pc                          = state_reg.pc;
   assign stack_top                   = state_reg.stk[0];
   assign work                        = state_reg.work;
   assign high_prio_global_irq_enable = state_reg.hp_irq_en;
   assign low_prio_global_irq_enable  = state_reg.lp_irq_en;
   assign soft_reset                  = state_reg.soft_rst;

endmodule

// >>> dv/rsc_fetch_model.sv
// Fetch unit model that offers one instruction word to the core.
`timescale 1ns/1ps
module rsc_fetch_model (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        go,
   input  wire logic [15:0] word,
   input  wire logic        instr_ready,
   output logic             instr_valid,
   output logic [15:0]      instr
);
   // A refused offer is held here, since the core keeps no copy of it.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         instr_valid <= 1'b0;
         instr       <= 16'h0000;
      end else if (go) begin
         instr_valid <= 1'b1;
         instr       <= word;
      end else if (instr_valid && instr_ready) begin
         instr_valid <= 1'b0;
         instr       <= ~instr;
      end
   end
endmodule

// >>> dv/rsc_chk_sva.sv
// Assertions on the ports of the return-stack control block.
`timescale 1ns/1ps
module rsc_chk #(
   parameter int PCW = 21
) (
   input wire logic               clk,
   input wire logic               nrst,
   input wire rsc_pkg::rsc_bus_t  bus,
   input wire logic               instr_valid,
   input wire logic [15:0]        instr,
   input wire logic               instr_ready,
   input wire rsc_pkg::rsc_work_t shadow,
   input wire logic               irq_exit_high,
   input wire logic [PCW-1:0]     pc,
   input wire logic [PCW-1:0]     stack_top,
   input wire rsc_pkg::rsc_work_t work,
   input wire logic               high_prio_global_irq_enable,
   input wire logic               low_prio_global_irq_enable,
   input wire logic               soft_reset
);
   wire logic           tk  = instr_valid && instr_ready && !bus.wr;
   wire logic           ir  = tk && instr[15:1] == rsc_pkg::OP_IRQ_RETURN;
   wire logic           rc  = tk && instr[15:11] == rsc_pkg::OP_REL_SUBCALL;
   wire logic [PCW-1:0] off = {{(PCW-12){instr[10]}}, instr[10:0], 1'b0};
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence flush_s;
      !instr_ready ##1 instr_ready;
   endsequence
   AST_DISCARD: assert property (tk && instr == 16'h0006 |=>
      pc == PCW'($past(pc) + 2) && work == $past(work) && instr_ready) else $error("bad discard");
   AST_CALL_TGT: assert property (rc |=> stack_top == PCW'($past(pc) + 2) &&
      pc == PCW'($past(pc) + 2 + $past(off))) else $error("bad call target");
   AST_CALL_FLUSH: assert property (rc |=> flush_s) else $error("bad call timing");
   AST_SRST: assert property (tk && instr == 16'h00ff |=> soft_reset && pc == '0 &&
      work == rsc_pkg::WORK_RESET ##1 !soft_reset) else $error("bad soft reset");
   AST_IRET_PC: assert property (ir |=> (pc == $past(stack_top)) ##0 flush_s)
      else $error("bad interrupt return");
   AST_IRET_EN: assert property (ir && irq_exit_high |=> high_prio_global_irq_enable)
      else $error("enable not set");
   AST_IRET_EN_LOW: assert property (ir && !irq_exit_high |=> low_prio_global_irq_enable)
      else $error("low enable not set");
   AST_IRET_FAST: assert property (ir |=>
      work == ($past(instr[0]) ? $past(shadow) : $past(work))) else $error("bad restore");
   AST_LITRET: assert property (tk && instr[15:8] == rsc_pkg::OP_LIT_RETURN |=>
      work.accum == $past(instr[7:0]) && pc == $past(stack_top)) else $error("bad literal");
endmodule

// >>> dv/tb_top.sv
// Self-checking testbench of the return-stack control block.
`timescale 1ns/1ps
module tb_top;
   logic               clk = 1'b0, nrst = 1'b0, go = 1'b0, hx = 1'b0, rd_d = 1'b0;
   logic               iv, rdy, hi, lo, sr;
   logic [15:0]        word = 16'h0000, ins;
   rsc_pkg::rsc_bus_t  bus = '0;
   rsc_pkg::rsc_work_t shadow = '0, wk;
   logic [31:0]        rdata, r, expq[$];
   logic [20:0]        pc, st, pc_m = '0, stk[$];
   logic [7:0]         acc_m = 8'h00;
   int                 fails = 0, comparisons = 0, i;
   always #20 clk = ~clk;
   rsc_core u_dut (.clk(clk), .nrst(nrst), .bus(bus), .bus_rdata(rdata), .instr_valid(iv),
      .instr(ins), .instr_ready(rdy), .shadow(shadow), .irq_exit_high(hx), .pc(pc),
      .stack_top(st), .work(wk), .high_prio_global_irq_enable(hi),
      .low_prio_global_irq_enable(lo), .soft_reset(sr));
   rsc_fetch_model u_fetch (.clk(clk), .nrst(nrst), .go(go), .word(word),
      .instr_ready(rdy), .instr_valid(iv), .instr(ins));
   always @(posedge clk) rd_d <= bus.rd;
   always @(negedge clk) begin
      if (rd_d) begin
         r = expq.pop_front();
         comparisons++;
         if (rdata !== r) begin
            fails++;
            $display("[ERR] %0t read %h expected %h", $time, rdata, r);
         end
      end
   end
   task automatic bw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic br(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
   endtask
   task automatic chk();
      br(rsc_pkg::ADDR_PC, {11'h0, pc_m});
      br(rsc_pkg::ADDR_STACK_TOP, {11'h0, stk.size() ? stk[0] : 21'h0});
      br(rsc_pkg::ADDR_ACCUM, {24'h0, acc_m});
   endtask
   // The model follows each instruction once the fetch model has seen it taken.
   task automatic ex(input logic [15:0] w);
      logic [20:0] t;
      @(posedge clk);
      word <= w;
      go   <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (8) begin
         #1;
         if (iv === 1'b0) break;
         @(posedge clk);
      end
      t = stk.size() ? stk[0] : 21'h0;
      pc_m = pc_m + 21'h2;
      if (w == 16'h0005 || w[15:11] == 5'h1b) stk.push_front(pc_m);
      if (w[15:11] == 5'h1b) pc_m = pc_m + {{9{w[10]}}, w[10:0], 1'b0};
      if (w == 16'h0006 || w[15:1] == 15'h0008 || w[15:8] == 8'h0c) void'(stk.pop_front());
      if (w[15:1] == 15'h0008 || w[15:8] == 8'h0c) pc_m = t;
      if (w[15:8] == 8'h0c) acc_m = w[7:0];
      if (w == 16'h0011) acc_m = shadow.accum;
   endtask
   task automatic give_verdict();
      repeat (3) @(posedge clk);
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #800000;
      fails++;
      $display("[ERR] %0t watchdog expired", $time);
      give_verdict();
   end
   initial begin
      void'($urandom(32'h68fc));
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      ex(16'h0005);
      r = $urandom;
      bw(rsc_pkg::ADDR_STACK_TOP, {11'h0, r[20:0]});
      stk[0] = r[20:0];
      ex(16'h0005);
      chk();
      ex(16'h0006);
      chk();
      $display("test stack done");
      for (i = 0; i < 4; i++) begin
         r = (i == 0) ? 32'h400 : (i == 1) ? 32'h3ff : (i == 2) ? 32'h0 : $urandom;
         ex({5'h1b, r[10:0]});
         chk();
      end
      $display("test call done");
      for (i = 0; i < 4; i++) begin
         r = $urandom;
         @(posedge clk);
         shadow <= 24'($urandom);
         hx     <= i[0];
         bw(rsc_pkg::ADDR_IRQ_ENABLE, 32'h0);
         bw(rsc_pkg::ADDR_FLAGS, {24'h0, r[7:0]});
         ex({15'h0008, i[1]});
         chk();
         br(rsc_pkg::ADDR_IRQ_ENABLE, i[0] ? 32'h1 : 32'h2);
         br(rsc_pkg::ADDR_FLAGS, {24'h0, i[1] ? shadow.flags : r[7:0]});
      end
      $display("test interrupt return done");
      for (i = 0; i < 3; i++) begin
         r = (i == 0) ? 32'h0 : (i == 1) ? 32'hff : $urandom;
         ex(16'h0005);
         ex({8'h0c, r[7:0]});
         chk();
      end
      $display("test literal return done");
      ex(16'h00ff);
      pc_m = 21'h0;
      stk.delete();
      acc_m = 8'h00;
      chk();
      br(rsc_pkg::ADDR_IRQ_ENABLE, 32'h0);
      bw(rsc_pkg::ADDR_PC, $urandom);
      br(rsc_pkg::ADDR_PC, {11'h0, pc_m});
      br(8'hfc, 32'h0);
      $display("test reset and bus done");
      give_verdict();
   end
endmodule
bind rsc_core rsc_chk #(.PCW(PCW)) u_chk (.clk(clk), .nrst(nrst), .bus(bus),
   .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .shadow(shadow),
   .irq_exit_high(irq_exit_high), .pc(pc), .stack_top(stack_top), .work(work),
   .high_prio_global_irq_enable(high_prio_global_irq_enable),
   .low_prio_global_irq_enable(low_prio_global_irq_enable), .soft_reset(soft_reset));
